// ### shared/mas_pkg.sv
package mas_pkg;

  // converter and multiplexer sizes
  localparam int unsigned MAS_RES_BITS   = 12;
  localparam int unsigned MAS_WORD_BITS  = 4;
  localparam int unsigned MAS_CHAN_SMALL = 4;
  localparam int unsigned MAS_CHAN_LARGE = 8;

  // device frame schedule, counted in link rising edges with select low
  localparam logic [5:0] MAS_K_ACQ       = 6'h02;
  localparam logic [5:0] MAS_K_NULL      = 6'h03;
  localparam logic [5:0] MAS_K_MSB_FIRST = 6'h04;
  localparam logic [5:0] MAS_K_MSB_LAST  = 6'h0F;
  localparam logic [5:0] MAS_K_LSB_LAST  = 6'h1A;
  localparam logic [5:0] MAS_K_MAX       = 6'h3F;

  // host view of the same schedule, one rising edge later
  localparam logic [4:0] MAS_H_MSB_FIRST = 5'h05;
  localparam logic [4:0] MAS_H_MSB_LAST  = 5'h10;
  localparam logic [4:0] MAS_H_LSB_LAST  = 5'h1B;
  localparam logic [2:0] MAS_H_WORD_LEN  = 3'h4;
  localparam logic       MAS_H_SKIP      = 1'b1;

  // link clock made by the host from clk_in
  localparam int unsigned MAS_CLK_PERIOD_NS  = 100;
  localparam int unsigned MAS_SCLK_PERIOD_NS = 800;
  localparam int unsigned MAS_HALF_CYCLES    =
    MAS_SCLK_PERIOD_NS / (2 * MAS_CLK_PERIOD_NS);
  localparam logic [2:0] MAS_HALF_LAST = 3'(MAS_HALF_CYCLES - 1);

  // values after reset
  localparam logic MAS_SEL_IDLE = 1'b1;

  typedef enum logic [1:0] {
    MAS_MUX_LOAD  = 2'b00,
    MAS_MUX_BREAK = 2'b01,
    MAS_MUX_MADE  = 2'b10
  } mas_mux_e;

  typedef enum logic [1:0] {
    MAS_H_IDLE   = 2'b00,
    MAS_H_SHIFT  = 2'b01,
    MAS_H_CONV   = 2'b10,
    MAS_H_FINISH = 2'b11
  } mas_host_e;

endpackage : mas_pkg

// ### shared/mas_if.sv
interface mas_if;
  logic sclk;
  logic channel_select_n;
  logic converter_select_n;
  logic host_data;
  logic host_oe;
  logic dev_data;
  logic dev_oe;
  logic data_line;

  // one shared data wire, pulled high when nobody drives
  assign data_line = dev_oe ? dev_data : (host_oe ? host_data : 1'b1);

  modport dev (
    input  sclk,
    input  channel_select_n,
    input  converter_select_n,
    input  data_line,
    output dev_data,
    output dev_oe
  );

  modport host (
    output sclk,
    output channel_select_n,
    output converter_select_n,
    output host_data,
    output host_oe,
    input  data_line
  );
endinterface : mas_if

// ### logic/mas_device.sv
// Function
// - launch on falling edge, sample on rising
// - word in first, result out afterwards
// - host raises select to start and reset
// - select high: shift input into 4-bit word
// - extra bits fine, last four kept
// - host lowers select before next rising edge
// - select falls: all off, then selected on
// - channel stays on until next select fall
// - one null bit before the result
// - 12-bit result, 4 or 8 channels
// - converter select high: off, output released
// - mux select high loads, low connects
// - host drives both selects together
// - link clock times transfers and conversion
// - converter powered only while converting
// - first word bit enables a channel
// - three address bits pick channel 0..CHAN_COUNT-1, others none
// - then comparator off, LSB-first repeat, zeroes
module mas_device
  import mas_pkg::*;
#(
  parameter int unsigned CHAN_COUNT = MAS_CHAN_LARGE
) (
  // link, clocked by the link clock
  mas_if.dev                 link,
  // reset
  input  wire  logic         sys_rst_in,
  // analog level at the converter input, quantised
  input  wire  logic [11:0]  converter_input_pin_in,
  // channel switches and converter status
  output logic       [7:0]   channel_on_out,
  output logic               converter_power_out,
  output logic               converting_out,
  output logic       [11:0]  held_sample_out,
  output logic       [11:0]  converted_word_out,
  output logic       [3:0]   stored_word_out
);

  // state updated on the rising link edge
  typedef struct packed {
    mas_mux_e    mux;
    logic [3:0]  word;
    logic [7:0]  chan_on;
    logic        conv;
    logic [5:0]  k;
    logic        powered;
    logic        busy;
    logic [11:0] sync1;
    logic [11:0] sync2;
  } mas_rise_s;

  // state updated on the falling link edge
  typedef struct packed {
    logic [11:0] held;
    logic [11:0] sar;
    logic        dout;
    logic        oe;
  } mas_fall_s;

  mas_rise_s r;
  mas_rise_s next_r;
  mas_fall_s f;
  mas_fall_s next_f;

  // enable bit plus channel address to one-hot switch pattern
  function automatic logic [7:0] mas_decode(input logic [3:0] w);
    logic [7:0] sel;
    sel = '0;
    if (w[3] && (32'(w[2:0]) < CHAN_COUNT)) begin
      sel = 8'(8'h01 << w[2:0]);
    end
    return sel;
  endfunction : mas_decode

  // result bit sent on the falling edge after rising edge k
  function automatic logic mas_tx_bit(input logic [5:0]  k,
                                      input logic [11:0] v);
    logic b;
    b = 1'b0;
    if (k >= MAS_K_MSB_FIRST && k <= MAS_K_MSB_LAST) begin
      b = v[4'(MAS_K_MSB_LAST - k)];
    end else if (k > MAS_K_MSB_LAST && k <= MAS_K_LSB_LAST) begin
      b = v[4'(k - MAS_K_MSB_LAST)];
    end
    return b;
  endfunction : mas_tx_bit

  // in-range window of the schedule counter
  function automatic logic mas_in(input logic [5:0] k,
                                  input logic [5:0] lo,
                                  input logic [5:0] hi);
    return (k >= lo) && (k <= hi);
  endfunction : mas_in

  always_comb begin
    next_r       = r;
    // analog level settles through two stages before the hold
    next_r.sync1 = converter_input_pin_in;
    next_r.sync2 = r.sync1;

    // multiplexer half, steered by its own select
    if (link.channel_select_n) begin
      // word taken on the rising edge while select is high
      next_r.mux  = MAS_MUX_LOAD;
      next_r.word = {r.word[2:0], link.data_line};
    end else begin
      case (r.mux)
        MAS_MUX_LOAD: begin
          // first edge after the fall: break every switch
          next_r.mux     = MAS_MUX_BREAK;
          next_r.chan_on = '0;
        end
        MAS_MUX_BREAK: begin
          // one edge later: make the addressed switch, if enabled
          next_r.mux     = MAS_MUX_MADE;
          next_r.chan_on = mas_decode(r.word);
        end
        MAS_MUX_MADE: begin
          next_r.mux = MAS_MUX_MADE;
        end
        default: begin
          next_r.mux = MAS_MUX_LOAD;
        end
      endcase
    end

    // converter half, steered by its own select
    if (link.converter_select_n) begin
      // select high resets the sequence and powers down
      next_r.conv    = 1'b0;
      next_r.k       = '0;
      next_r.powered = 1'b0;
      next_r.busy    = 1'b0;
    end else begin
      next_r.conv = 1'b1;
      if (r.k != MAS_K_MAX) begin
        next_r.k = 6'(r.k + 6'h01);
      end
      // bias on from acquisition to the last decision
      next_r.powered = mas_in(next_r.k, MAS_K_ACQ,
                              MAS_K_MSB_LAST);
      next_r.busy    = mas_in(next_r.k, MAS_K_ACQ, MAS_K_MSB_LAST);
    end
  end

  always_comb begin
    next_f = f;
    if (!r.conv) begin
      // released until the null bit, so the host may drive
      next_f.oe   = 1'b0;
      next_f.dout = 1'b0;
    end else if (r.k == MAS_K_NULL) begin
      // hold closes 1.5 cycles after the switch made
      next_f.held = r.sync2;
      next_f.sar  = '0;
      next_f.oe   = 1'b1;
      next_f.dout = 1'b0;
    end else if (r.k > MAS_K_NULL) begin
      next_f.oe   = 1'b1;
      next_f.dout = mas_tx_bit(r.k, f.held);
      if (mas_in(r.k, MAS_K_MSB_FIRST, MAS_K_MSB_LAST)) begin
        // one approximation step per link cycle
        next_f.sar[4'(MAS_K_MSB_LAST - r.k)] =
          f.held[4'(MAS_K_MSB_LAST - r.k)];
      end
    end else begin
      next_f.oe   = 1'b0;
      next_f.dout = 1'b0;
    end
  end

  always_ff @(posedge link.sclk or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // outgoing bits change on the falling edge
  always_ff @(negedge link.sclk or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  assign link.dev_data       = f.dout;
  assign link.dev_oe         = f.oe;
  assign channel_on_out      = r.chan_on;
  assign converter_power_out = r.powered;
  assign converting_out      = r.busy;
  assign held_sample_out     = f.held;
  assign converted_word_out  = f.sar;
  assign stored_word_out     = r.word;

endmodule : mas_device

// ### logic/mas_host.sv
module mas_host
  import mas_pkg::*;
(
  // clock and reset
  input  wire  logic         clk_in,
  input  wire  logic         sys_rst_in,
  // link to the converter
  mas_if.host                link,
  // conversion request
  input  wire  logic         req_valid_in,
  input  wire  logic         req_enable_in,
  input  wire  logic [2:0]   req_addr_in,
  output logic               req_ready_out,
  // conversion answer
  output logic               result_valid_out,
  output logic       [11:0]  result_out,
  output logic               result_mismatch_out
);

  typedef struct packed {
    mas_host_e   state;
    logic [2:0]  div;
    logic        sclk;
    logic        sel_n;
    logic        hdat;
    logic        hoe;
    logic [3:0]  word;
    logic [2:0]  bitc;
    logic        skip;
    logic [4:0]  k;
    logic [11:0] msb;
    logic [10:0] lsb;
    logic        sync1;
    logic        sync2;
    logic [11:0] result;
    logic        valid;
    logic        mismatch;
    logic        ready;
  } mas_host_s;

  localparam mas_host_s HOST_RST = '{
    state: MAS_H_IDLE, sel_n: MAS_SEL_IDLE, default: '0};

  mas_host_s h;
  mas_host_s next_h;
  logic      rise;
  logic      fall;

  always_comb begin
    next_h       = h;
    next_h.sync1 = link.data_line;
    next_h.sync2 = h.sync1;
    next_h.valid = 1'b0;
    rise         = 1'b0;
    fall         = 1'b0;

    // link clock divider, stopped low while idle
    if (h.state != MAS_H_IDLE) begin
      if (h.div == MAS_HALF_LAST) begin
        next_h.div  = '0;
        next_h.sclk = !h.sclk;
        rise        = !h.sclk;
        fall        = h.sclk;
      end else begin
        next_h.div = 3'(h.div + 3'h1);
      end
    end

    case (h.state)
      MAS_H_IDLE: begin
        next_h.ready = 1'b1;
        if (req_valid_in && h.ready) begin
          next_h.ready = 1'b0;
          next_h.word  = {req_enable_in, req_addr_in};
          next_h.bitc  = '0;
          next_h.skip  = MAS_H_SKIP;
          next_h.div   = '0;
          next_h.state = MAS_H_SHIFT;
        end
      end
      MAS_H_SHIFT: begin
        if (fall) begin
          if (h.skip) begin
            // device lets go of the wire on this edge
            next_h.skip = 1'b0;
          end else if (h.bitc == MAS_H_WORD_LEN) begin
            // lower both selects before the next rising edge
            next_h.sel_n = 1'b0;
            next_h.hoe   = 1'b0;
            next_h.k     = '0;
            next_h.state = MAS_H_CONV;
          end else begin
            next_h.hdat = h.word[3];
            next_h.hoe  = 1'b1;
            next_h.word = {h.word[2:0], 1'b0};
            next_h.bitc = 3'(h.bitc + 3'h1);
          end
        end
      end
      MAS_H_CONV: begin
        if (rise) begin
          next_h.k = 5'(h.k + 5'h01);
          if (next_h.k >= MAS_H_MSB_FIRST &&
              next_h.k <= MAS_H_MSB_LAST) begin
            next_h.msb = {h.msb[10:0], h.sync2};
          end else if (next_h.k > MAS_H_MSB_LAST &&
                       next_h.k <= MAS_H_LSB_LAST) begin
            next_h.lsb = {h.sync2, h.lsb[10:1]};
          end
          if (next_h.k == MAS_H_LSB_LAST) begin
            next_h.state = MAS_H_FINISH;
          end
        end
      end
      MAS_H_FINISH: begin
        if (fall) begin
          // raising the selects resets the device for the next frame
          next_h.sel_n    = 1'b1;
          next_h.result   = h.msb;
          next_h.mismatch = (h.msb[11:1] != h.lsb);
          next_h.valid    = 1'b1;
          next_h.state    = MAS_H_IDLE;
        end
      end
      default: begin
        next_h.state = MAS_H_IDLE;
        next_h.sel_n = MAS_SEL_IDLE;
        next_h.hoe   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      h <= HOST_RST;
    end else begin
      h <= next_h;
    end
  end

  assign link.sclk               = h.sclk;
  assign link.channel_select_n   = h.sel_n;
  assign link.converter_select_n = h.sel_n;
  assign link.host_data          = h.hdat;
  assign link.host_oe            = h.hoe;
  assign req_ready_out           = h.ready;
  assign result_valid_out        = h.valid;
  assign result_out              = h.result;
  assign result_mismatch_out     = h.mismatch;

endmodule : mas_host

// ### verification/mas_asserts.sv
module mas_asserts (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // link signals
  input  wire logic sclk,
  input  wire logic channel_select_n,
  input  wire logic converter_select_n,
  input  wire logic host_oe,
  input  wire logic dev_oe,
  input  wire logic dev_data,
  input  wire logic data_line
);
  timeunit 1ns;
  timeprecision 1ns;

  // sclk rises seen with select low, before this edge
  logic [5:0] k_seen;

  always_ff @(posedge sclk or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      k_seen <= 6'h00;
    end else if (converter_select_n) begin
      k_seen <= 6'h00;
    end else if (k_seen != 6'h3F) begin
      k_seen <= k_seen + 6'h01;
    end
  end

  chk_sel_tied: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    channel_select_n == converter_select_n
  ) else $error("selects differ");
  chk_wire_single: assert property (
    @(posedge clk_in) disable iff (sys_rst_in) !(host_oe && dev_oe)
  ) else $error("both ends drive the data wire");
  chk_host_quiet: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    host_oe |-> converter_select_n
  ) else $error("host drives while selected");
  chk_sel_sclk_low: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    $changed(converter_select_n) |-> !sclk
  ) else $error("select moved while sclk high");
  chk_data_hold: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    sclk && $past(sclk) |-> $stable(data_line)
  ) else $error("data moved while sclk high");
  chk_sclk_rate: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(sclk) |=> sclk [*3] ##1 !sclk
  ) else $error("sclk high phase wrong");
  chk_null_bit: assert property (
    @(posedge sclk) disable iff (sys_rst_in)
    k_seen == 6'h03 && !converter_select_n |-> dev_oe && !dev_data
  ) else $error("null bit missing");
  chk_dev_released: assert property (
    @(posedge sclk) disable iff (sys_rst_in)
    k_seen < 6'h03 |-> !dev_oe
  ) else $error("device drives too early");
  chk_dev_owns: assert property (
    @(posedge sclk) disable iff (sys_rst_in)
    k_seen inside {[6'h03:6'h1A]} && !converter_select_n |-> dev_oe
  ) else $error("device released during result");

  cov_frame: cover property (@(posedge sclk) k_seen == 6'h1A);
  cov_null: cover property (@(posedge sclk) $rose(dev_oe));
  cov_host: cover property (@(posedge clk_in) $rose(host_oe));
endmodule : mas_asserts

// ### verification/tb.sv
module tb import mas_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in;
  logic        sys_rst_in;
  logic        rq_v;
  logic        rq_en;
  logic [2:0]  rq_a;
  logic        rdy;
  logic        res_v;
  logic [11:0] res;
  logic        mism;
  logic [11:0] pin_val;
  logic [7:0]  on_a;
  logic [7:0]  on_b;
  logic        pwr;
  logic        busy;
  logic [11:0] held;
  logic [11:0] sar;
  logic [3:0]  word_a;
  logic [3:0]  word_b;
  logic [11:0] vals [8] = '{12'h000, 12'h801, 12'h5A2, 12'hA53,
                            12'h0F4, 12'hF05, 12'h3C6, 12'hFFF};
  int          mismatches;
  int          check_count;
  int          cycles;
  mas_if       lk ();
  mas_if       lk_b ();

  mas_host i_mas_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .link(lk), .req_valid_in(rq_v), .req_enable_in(rq_en),
    .req_addr_in(rq_a), .req_ready_out(rdy), .result_valid_out(res_v),
    .result_out(res), .result_mismatch_out(mism));
  mas_device #(.CHAN_COUNT(MAS_CHAN_LARGE)) i_mas_device (.link(lk),
    .sys_rst_in(sys_rst_in), .converter_input_pin_in(pin_val),
    .channel_on_out(on_a), .converter_power_out(pwr),
    .converting_out(busy), .held_sample_out(held),
    .converted_word_out(sar),
    .stored_word_out(word_a));
  mas_device #(.CHAN_COUNT(MAS_CHAN_SMALL)) i_mas_device_small (
    .link(lk_b), .sys_rst_in(sys_rst_in),
    .converter_input_pin_in(pin_val), .channel_on_out(on_b),
    .converter_power_out(), .converting_out(), .held_sample_out(),
    .converted_word_out(), .stored_word_out(word_b));
  mas_asserts i_mas_asserts (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .sclk(lk.sclk), .channel_select_n(lk.channel_select_n),
    .converter_select_n(lk.converter_select_n), .host_oe(lk.host_oe),
    .dev_oe(lk.dev_oe), .dev_data(lk.dev_data),
    .data_line(lk.data_line));

  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic convert(input logic en, input logic [2:0] a,
                         input logic [11:0] v);
    logic [11:0] on;
    on = en ? 12'h001 << a : 12'h000;
    wait (rdy === 1'b1);
    @(posedge clk_in);
    #1;
    pin_val = v;
    rq_v = 1'b1;
    rq_en = en;
    rq_a = a;
    @(posedge clk_in);
    #1;
    rq_v = 1'b0;
    @(negedge lk.converter_select_n);
    @(posedge lk.sclk);
    #1;
    check("all off", {4'h0, on_a}, 12'h000);
    @(posedge lk.sclk);
    #1;
    check("made", {4'h0, on_a}, on);
    check("power on", {11'h0, pwr}, 12'h001);
    check("busy on", {11'h0, busy}, 12'h001);
    @(posedge res_v);
    #1;
    check("result", res, v);
    check("echo", {11'h0, mism}, 12'h000);
    check("held", {4'h0, on_a}, on);
    check("power off", {11'h0, pwr}, 12'h000);
    check("busy off", {11'h0, busy}, 12'h000);
    check("sample", held, v);
    check("sar word", sar, v);
    check("word", {8'h0, word_a}, {8'h0, en, a});
    $display("test convert en %0d ch %0d done", en, a);
  endtask : convert

  task automatic pulse_b();
    #24 lk_b.sclk = 1'b1;
    #24 lk_b.sclk = 1'b0;
  endtask : pulse_b

  task automatic frame_b(input logic [5:0] bits, input logic [11:0] on,
                         input logic [11:0] v);
    logic [11:0] got;
    logic [11:0] echo;
    pin_val = v;
    lk_b.channel_select_n = 1'b1;
    lk_b.converter_select_n = 1'b1;
    lk_b.host_oe = 1'b0;
    pulse_b();
    lk_b.host_oe = 1'b1;
    for (int i = 5; i >= 0; i--) begin
      lk_b.host_data = bits[i];
      pulse_b();
    end
    lk_b.channel_select_n = 1'b0;
    lk_b.converter_select_n = 1'b0;
    lk_b.host_oe = 1'b0;
    check("word b", {8'h0, word_b}, {8'h0, bits[3:0]});
    for (int k = 1; k <= 27; k++) begin
      // sample settled values just before rising edge k
      #24;
      if (k == 4) check("null", {11'h0, lk_b.data_line}, 12'h000);
      if (k == 3) check("chan b", {4'h0, on_b}, on);
      if (k >= 5 && k <= 16) got[16-k] = lk_b.data_line;
      if (k >= 17) begin
        echo = {11'h0, got[k-16]};
        check("lsb", {11'h0, lk_b.data_line}, echo);
      end
      lk_b.sclk = 1'b1;
      #24 lk_b.sclk = 1'b0;
    end
    check("msb", got, v);
    lk_b.channel_select_n = 1'b1;
    lk_b.converter_select_n = 1'b1;
    pulse_b();
    // let the falling-edge release settle before looking
    #1;
    check("hi z", {11'h0, lk_b.data_line}, 12'h001);
    check("kept b", {4'h0, on_b}, on);
    $display("test small frame %h done", bits);
  endtask : frame_b

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    sys_rst_in = 1'b1;
    rq_v = 1'b0;
    rq_en = 1'b0;
    rq_a = 3'h0;
    pin_val = 12'h000;
    lk_b.sclk = 1'b0;
    lk_b.channel_select_n = 1'b1;
    lk_b.converter_select_n = 1'b1;
    lk_b.host_oe = 1'b0;
    lk_b.host_data = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    check("idle sel", {11'h0, lk.converter_select_n}, 12'h001);
    sys_rst_in = 1'b0;
    for (int a = 0; a < 8; a++) begin
      convert(1'b1, a[2:0], vals[a]);
    end
    convert(1'b0, 3'h5, 12'h6B9);
    frame_b(6'h2B, 12'h008, 12'hC35);
    frame_b(6'h1C, 12'h000, 12'h3CA);
    conclude();
  end
endmodule : tb
